// >>> i2s_pkg.sv
`default_nettype none
package i2s_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL_B = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_FLAG = 4'h8;
  localparam logic [3:0] OFS_INT_MASK = 4'hc;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  // control b fields
  localparam int CTRL_ACK_POS = 18;
  localparam int CTRL_CMD_LO = 16;
  localparam logic [1:0] CMD_CLOSE = 2'h3;
  // status word fields: low byte is the data register
  localparam int CFG_SMART_POS = 8;
  // interrupt flag positions
  localparam int FLAG_STOP = 0;
  localparam int FLAG_ADDR_MATCH = 1;
  localparam int FLAG_DATA_READY = 2;
  localparam logic [2:0] FLAGS_ALL = 3'h7;
  // reset values
  localparam logic [31:0] RST_CTRL_B = 32'h0000_0000;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic RST_SMART = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDRESSED,
    ST_DATA
  } i2s_state_type;

  typedef struct packed {
    logic stop;
    logic addr_match;
    logic data_ready;
  } i2s_event_type;
endpackage
`default_nettype wire

// >>> i2s_slave_ctl.sv
`default_nettype none
module i2s_slave_ctl
  import i2s_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // events from the serial engine
  input wire i2s_event_type evt_i,
  input wire logic [7:0] rx_byte_i,
  // to the serial engine, and the interrupt line
  output logic ack_action_bit_o,
  output logic addr_ack_o,
  output logic [7:0] tx_byte_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////
  // state
  logic [31:0] slave_control_b;
  logic [2:0] interrupt_flag_reg;
  logic [2:0] int_mask;
  logic smart_mode;
  i2s_state_type state;
  i2s_state_type next_state;
  logic [2:0] next_flags;
  logic [31:0] rd_mux;

  // only data ready is dropped by a data access
  localparam logic [2:0] DATA_READY_ONLY = 3'(1 << FLAG_DATA_READY);

  ////////////////////////////////////////////////////////////////
  // helpers
  // address compare shared by every register select
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    return adr == ofs;
  endfunction

  // gate a clear mask with its strobe
  function automatic logic [2:0] gate3(input logic en, input logic [2:0] bits);
    return en ? bits : 3'h0;
  endfunction

  // engine events in flag order
  function automatic logic [2:0] ev_bits(input i2s_event_type ev);
    logic [2:0] v;
    v = 3'h0;
    v[FLAG_STOP] = ev.stop;
    v[FLAG_ADDR_MATCH] = ev.addr_match;
    v[FLAG_DATA_READY] = ev.data_ready;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus decode
  // request phase: taken while no answer is outstanding
  wire logic req = cyc_i && stb_i && !ack_o && !err_o;
  // data phase: the edge where the master sees ack; writes land only here
  wire logic data_ph = cyc_i && stb_i && ack_o;
  wire logic wr_ph = data_ph && we_i;
  wire logic rd_ph = data_ph && !we_i;
  wire logic sel_ctrl = hit(adr_i, OFS_CTRL_B);
  wire logic sel_stat = hit(adr_i, OFS_STATUS);
  wire logic sel_flag = hit(adr_i, OFS_INT_FLAG);
  wire logic sel_mask = hit(adr_i, OFS_INT_MASK);
  wire logic mapped = sel_ctrl || sel_stat || sel_flag || sel_mask;
  wire logic rd_req = req && !we_i && mapped;

  // write strobes, each qualified by its byte lane
  wire logic wr_ctrl = wr_ph && sel_ctrl && sel_i[2];
  wire logic wr_flag = wr_ph && sel_flag && sel_i[0];
  wire logic wr_mask = wr_ph && sel_mask && sel_i[0];
  wire logic wr_tx = wr_ph && sel_stat && sel_i[0];
  wire logic wr_smart = wr_ph && sel_stat && sel_i[1];
  // any read of the data word, or a write of its low byte, is a data access
  wire logic data_touch = (rd_ph && sel_stat) || wr_tx;
  wire logic cmd_close = wr_ctrl && dat_i[CTRL_CMD_LO +: 2] == CMD_CLOSE;
  // command is a strobe, never stored, so it cannot fire a second time
  wire logic [31:0] ctrl_wdata = {dat_i[31:CTRL_CMD_LO + 2], 2'h0, dat_i[CTRL_CMD_LO - 1:0]};

  ////////////////////////////////////////////////////////////////
  // interrupt flags
  wire logic [2:0] ev_set = ev_bits(evt_i);
  wire logic [2:0] sw_clr = gate3(wr_flag, dat_i[2:0]);
  wire logic [2:0] cmd_clr = gate3(cmd_close, FLAGS_ALL);
  wire logic [2:0] smart_clr = gate3(smart_mode && data_touch, DATA_READY_ONLY);
  wire logic [2:0] all_clr = sw_clr | cmd_clr | smart_clr;
  // set beats clear, so an event landing with a clear is never lost
  assign next_flags = (interrupt_flag_reg & ~all_clr) | ev_set;
  wire logic irq_next = |(next_flags & int_mask);

  ////////////////////////////////////////////////////////////////
  // read data; command bits always read back as zero
  wire logic [31:0] stat_word = {23'h0, smart_mode, rx_byte_i};
  assign rd_mux = sel_ctrl ? slave_control_b :
                  sel_stat ? stat_word :
                  sel_flag ? {29'h0, interrupt_flag_reg} :
                  sel_mask ? {29'h0, int_mask} :
                  32'h0;

  ////////////////////////////////////////////////////////////////
  // slave progress moves only on engine events or the close command
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (evt_i.addr_match) begin
          next_state = ST_ADDRESSED;
        end
      end
      ST_ADDRESSED: begin
        if (cmd_close) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (evt_i.stop) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // bus answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
    end
  end

  // read data holds until the next mapped read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (ce_i && rd_req) begin
      dat_o <= rd_mux;
    end
  end

  // control b only stores fields; the slave state is never touched here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_control_b <= RST_CTRL_B;
    end else if (ce_i && wr_ctrl) begin
      slave_control_b <= ctrl_wdata;
    end
  end

  // ack action feeds the engine, so it keeps a flop of its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_action_bit_o <= RST_CTRL_B[CTRL_ACK_POS];
    end else if (ce_i && wr_ctrl) begin
      ack_action_bit_o <= dat_i[CTRL_ACK_POS];
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask <= RST_MASK;
    end else if (ce_i && wr_mask) begin
      int_mask <= dat_i[2:0];
    end
  end

  // smart mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smart_mode <= RST_SMART;
    end else if (ce_i && wr_smart) begin
      smart_mode <= dat_i[CFG_SMART_POS];
    end
  end

  // transmit byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_byte_o <= 8'h0;
    end else if (ce_i && wr_tx) begin
      tx_byte_o <= dat_i[7:0];
    end
  end

  // sticky flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_flag_reg <= 3'h0;
    end else if (ce_i) begin
      interrupt_flag_reg <= next_flags;
    end
  end

  // level interrupt, registered from the next flag value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= irq_next;
    end
  end

  // slave state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // address acknowledge pulse to the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ack_o <= 1'b0;
    end else if (ce_i) begin
      addr_ack_o <= cmd_close && state == ST_ADDRESSED;
    end
  end
endmodule
`default_nettype wire

// >>> i2s_engine_model.sv
`default_nettype none
module i2s_engine_model
  import i2s_pkg::*;
(
  input wire logic clk_i,
  input wire logic [2:0] go_i,
  output var i2s_event_type evt_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // engine events are single-cycle pulses
  always_ff @(posedge clk_i) evt_o <= go_i;
  assign byte_o = 8'h5a;
endmodule
`default_nettype wire

// >>> i2s_slave_ctl_asserts.sv
`default_nettype none
module i2s_ctl_asserts
  import i2s_pkg::*;
(
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, addr_ack_o,
  input wire logic [3:0] adr_i, sel_i,
  input wire logic [31:0] dat_i,
  input wire i2s_event_type evt_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr = cyc_i && stb_i && we_i && ack_o;
  wire logic wc = wr && adr_i == 4'h0 && sel_i[2];
  wire logic cls = wc && dat_i[17:16] == CMD_CLOSE;
  wire logic fclr = wr && adr_i == 4'h8 && sel_i[0] && dat_i[2:0] == FLAGS_ALL;
  property p_close; cls && evt_i == 3'h0 |-> ##[1:2] !irq_o; endproperty
  a_close: assert property (p_close) else $error("irq after close");
  property p_flag; fclr && evt_i == 3'h0 |-> ##[1:2] !irq_o; endproperty
  a_flag: assert property (p_flag) else $error("irq after flag clear");
  property p_addr; $rose(addr_ack_o) |-> $past(cls) || $past(cls, 2); endproperty
  a_addr: assert property (p_addr) else $error("stray address ack");
  property p_keep; wc && dat_i[17:16] == 2'h0 && irq_o |=> irq_o; endproperty
  a_keep: assert property (p_keep) else $error("flags lost on write");
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  // the main paths: close, flag clear, address ack
  c_close: cover property (cls);
  c_flag: cover property (fclr);
  c_addr: cover property (addr_ack_o);
endmodule
bind i2s_slave_ctl i2s_ctl_asserts chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
  .irq_o, .addr_ack_o, .adr_i, .sel_i, .dat_i, .evt_i);
`default_nettype wire

// >>> i2s_slave_ctl_bench.sv
`default_nettype none
module i2s_slave_ctl_bench
  import i2s_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, err, e, irq, aa, aq;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] dd = 0, rd, dato;
  logic [2:0] go = 0;
  logic [7:0] rxb, tx;
  logic [35:0] rows [3] = '{{4'hc, 32'h7}, {4'h0, 32'h0}, {4'h8, 32'h0}};
  i2s_event_type evt;
  int num_errors = 0, compares = 0, ack_pulses = 0;
  // address acknowledge is a one-cycle pulse: count it as it passes
  always @(posedge clk_i) if (aq) ack_pulses <= ack_pulses + 1;
  initial forever #5 clk_i = ~clk_i;
  i2s_engine_model eng_u (.clk_i, .go_i(go), .evt_o(evt), .byte_o(rxb));
  i2s_slave_ctl dut_u (.clk_i, .rst_i, .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dd), .dat_o(dato), .ack_o(ack), .err_o(err),
    .evt_i(evt), .rx_byte_i(rxb), .ack_action_bit_o(aa), .addr_ack_o(aq), .tx_byte_o(tx),
    .irq_o(irq));
  task automatic chk(input string n, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  // one bus cycle, then two idle edges so irq has settled
  task automatic wb(input logic [3:0] a, input logic w, input logic [3:0] s, logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dd} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (!(ack || err));
    rd = dato;
    e = err;
    {cyc, stb} <= 2'b00;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic ev(input logic [2:0] v);
    @(posedge clk_i);
    go <= v;
    @(posedge clk_i);
    go <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    chk("irq", 0, irq);
    wb(4'hc, 1, 4'h1, 32'h7);
    chk("ack_action", 0, aa);
    wb(4'h4, 1, 4'h1, 32'ha5);
    chk("tx", 32'ha5, tx);
    foreach (rows[i]) begin
      wb(rows[i][35:32], 0, 4'hf, 0);
      chk("read", rows[i][31:0], rd);
    end
    ev(3'b010);
    wb(4'h8, 1, 4'h1, 32'h2);
    chk("irq", 0, irq);
    ev(3'b010);
    wb(4'h4, 1, 4'h1, 32'h0);
    wb(4'h0, 1, 4'h4, 32'h4_0000);
    chk("ack_action", 1, aa);
    chk("irq", 1, irq);
    ev(3'b100);
    wb(4'h0, 1, 4'h4, 32'h3_0000);
    chk("irq", 0, irq);
    chk("addr_ack", 1, ack_pulses);
    wb(4'h8, 0, 4'hf, 0);
    chk("flags", 0, rd);
    ev(3'b001);
    wb(4'h4, 0, 4'hf, 0);
    chk("irq", 1, irq);
    wb(4'h8, 1, 4'h1, 32'h7);
    chk("irq", 0, irq);
    wb(4'h4, 1, 4'h2, 32'h100);
    ev(3'b001);
    wb(4'h4, 0, 4'hf, 0);
    chk("status", 32'h15a, rd);
    chk("irq", 0, irq);
    // old flag habits: drop stop only when it is up
    ev(3'b100);
    wb(4'h8, 0, 4'hf, 0);
    if (rd[FLAG_STOP]) wb(4'h8, 1, 4'h1, 32'h1);
    wb(4'h8, 0, 4'hf, 0);
    chk("flags", 0, rd);
    wb(4'h2, 0, 4'hf, 0);
    chk("err", 1, e);
    // frozen enable: an engine event must not reach the flags
    ce <= 1'b0;
    ev(3'b010);
    ce <= 1'b1;
    chk("irq", 0, irq);
    // mid-run reset with a flag pending
    ev(3'b010);
    chk("irq", 1, irq);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq", 0, irq);
    wb(4'h8, 0, 4'hf, 0);
    chk("flags", 0, rd);
    give_verdict;
  end
endmodule
`default_nettype wire
